// ===== flash_host_regs.vh
// constants for the parallel nor flash host controller
// assumes a word-mode flash with active-low strobes on a 40 MHz clock
// Functional notes
// (RULE1) query offsets 40h-42h read P, R, I
// (RULE2) major version 0031h, minor 0030h
// (RULE3) offset 45h reads 0000h, unlock required
// (RULE4) offset 46h reads 0002h, suspend read/write
// (RULE5) offsets 47h, 48h each read 0001h
// (RULE6) offsets 4Ah to 4Ch read 0000h
// (RULE7) program and erase need unlock cycles first
// (RULE8) secured region 128 words, lock refuses writes
// (RULE9) lowest data line shows secured lock state
// (RULE10) secured region maps onto top or bottom sector
// (RULE11) secured mode blocks array until exit sequence
// (RULE12) reset returns normal mapping, leaves secured mode
// (RULE13) low supply ignores writes and resets device
// (RULE14) host holds strobes inactive above lockout level
// (RULE15) write needs select and write low, gate high
// (RULE16) all three strobes low means read; the host reads with select and gate low, write held high
// (RULE17) power-up locks out commands, array read
// (RULE18) wrong sequence aborts to array read
// (RULE19) F0 to any address returns array read
// (RULE20) query reads zero upper address, end with reset
// (RULE21) query data on low byte, upper zero
`ifndef FLASH_HOST_REGS_VH
`define FLASH_HOST_REGS_VH
`define ADDR_UNLOCK1 20'h0_0555
`define ADDR_UNLOCK2 20'h0_02AA
`define ADDR_QUERY 20'h0_0055
`define DATA_UNLOCK1 16'h00AA
`define DATA_UNLOCK2 16'h0055
`define DATA_PROGRAM 16'h00A0
`define DATA_ERASE 16'h0080
`define DATA_SECTOR_ERASE 16'h0030
`define DATA_CHIP_ERASE 16'h0010
`define DATA_QUERY 16'h0098
`define DATA_RESET 16'h00F0
`define DATA_SEC_ENTER 16'h0088
`define DATA_SEC_EXIT1 16'h0090
`define DATA_SEC_EXIT2 16'h0000
`define OP_READ 3'h0
`define OP_PROGRAM 3'h1
`define OP_SECTOR_ERASE 3'h2
`define OP_CHIP_ERASE 3'h3
`define OP_QUERY 3'h4
`define OP_RESET 3'h5
`define OP_SEC_ENTER 3'h6
`define OP_SEC_EXIT 3'h7
`define CLK_PERIOD_NS 25
`define T_SETUP_NS 50
`define T_PULSE_NS 50
`define T_RECOVER_NS 30
`define T_ACCESS_NS 80
`define CYC_SYNC 2
`define CYC_SETUP ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_PULSE ((`T_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_RECOVER ((`T_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_ACCESS ((`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ===== flash_bus_cycle.v
// one strobed bus cycle (read or write) on the flash pins
// assumes the caller holds start for one cycle while not busy
`timescale 1ns/1ps
`include "flash_host_regs.vh"
module flash_bus_cycle (
  input wire clk_sys,
  input wire rst_b,
  input wire start,
  input wire is_write,
  input wire [19:0] addr,
  input wire [15:0] wdata,
  input wire [15:0] pin_dq_in,
  output reg busy,
  output reg done,
  output reg [15:0] rdata,
  output reg [19:0] pin_addr,
  output reg [15:0] pin_dq_out,
  output reg pin_dq_oe,
  output reg chip_sel_b,
  output reg write_b,
  output reg gate_b
);
  localparam ST_IDLE = 2'd0;
  localparam ST_SETUP = 2'd1;
  localparam ST_PULSE = 2'd2;
  localparam ST_RECOVER = 2'd3;
  reg [1:0] state;
  reg [3:0] count;
  reg writing;
  reg [15:0] dq_s1;
  reg [15:0] dq_s2;
  // timing counts as plain words, cut to the 4-bit counter on purpose
  localparam [31:0] SETUP_CYC = `CYC_SETUP;
  localparam [31:0] PULSE_CYC = `CYC_PULSE;
  // read waits out the access time plus the data synchroniser
  localparam [31:0] READ_CYC = `CYC_ACCESS + `CYC_SYNC;
  localparam [31:0] RECOVER_CYC = `CYC_RECOVER;

  // data pins come from another domain, two stages before use
  always @(posedge clk_sys) begin
    dq_s1 <= pin_dq_in;
    dq_s2 <= dq_s1;
  end

  // strobe sequencer; write never overlaps gate low
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      count <= 4'h0;
      writing <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
      pin_addr <= 20'h0_0000;
      pin_dq_out <= 16'h0000;
      pin_dq_oe <= 1'b0;
      chip_sel_b <= 1'b1; // see (RULE14)
      write_b <= 1'b1; // see (RULE14)
      gate_b <= 1'b1;
    end else begin
      done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start) begin
            busy <= 1'b1;
            writing <= is_write;
            pin_addr <= addr;
            pin_dq_out <= wdata;
            pin_dq_oe <= is_write;
            chip_sel_b <= 1'b0;
            count <= SETUP_CYC[3:0];
            state <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (count > 4'h1) begin
            count <= count - 4'h1;
          end else begin
            // write: select and write low, gate high (see (RULE15))
            // read: gate low, write held high (see (RULE16))
            write_b <= ~writing;
            gate_b <= writing;
            count <= writing ? PULSE_CYC[3:0] : READ_CYC[3:0];
            state <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          if (count > 4'h1) begin
            count <= count - 4'h1;
          end else begin
            if (!writing) begin
              rdata <= dq_s2;
            end
            write_b <= 1'b1;
            gate_b <= 1'b1;
            count <= RECOVER_CYC[3:0];
            state <= ST_RECOVER;
          end
        end
        ST_RECOVER: begin
          if (count > 4'h1) begin
            count <= count - 4'h1;
          end else begin
            chip_sel_b <= 1'b1;
            pin_dq_oe <= 1'b0;
            busy <= 1'b0;
            done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

// ===== flash_host.v
// host controller driving an asynchronous nor flash through its pins
// assumes a word-mode part; the user issues one operation at a time
`timescale 1ns/1ps
`include "flash_host_regs.vh"
module flash_host (
  input wire clk_sys,
  input wire rst_b,
  input wire op_valid,
  input wire [2:0] op_code,
  input wire [19:0] op_addr,
  input wire [15:0] op_data,
  input wire supply_low,
  input wire [15:0] pin_dq_in,
  output reg op_ready,
  output reg op_done,
  output reg [15:0] op_rdata,
  output reg secured_mode,
  output reg query_mode,
  output reg [19:0] pin_addr,
  output reg [15:0] pin_dq_out,
  output reg pin_dq_oe,
  output reg chip_sel_b,
  output reg write_b,
  output reg gate_b
);
  localparam ST_IDLE = 2'd0;
  localparam ST_ISSUE = 2'd1;
  localparam ST_WAIT = 2'd2;
  reg [1:0] state;
  reg [2:0] op;
  reg [19:0] target;
  reg [15:0] payload;
  reg [2:0] step;
  reg [2:0] last_step;
  reg low_s1;
  reg low_s2;
  reg cyc_start;
  reg cyc_write;
  reg [19:0] cyc_addr;
  reg [15:0] cyc_data;
  wire cyc_busy;
  wire cyc_done;
  wire [15:0] cyc_rdata;
  wire [19:0] b_addr;
  wire [15:0] b_dq;
  wire b_oe;
  wire b_cs;
  wire b_we;
  wire b_oe_b;

  // supply monitor is asynchronous: two stages
  always @(posedge clk_sys) begin
    low_s1 <= supply_low;
    low_s2 <= low_s1;
  end

  // number of bus cycles in each sequence, zero-based
  always @* begin
    case (op)
      `OP_PROGRAM: last_step = 3'd3; // see (RULE7)
      `OP_SECTOR_ERASE: last_step = 3'd5; // see (RULE7)
      `OP_CHIP_ERASE: last_step = 3'd5;
      `OP_SEC_ENTER: last_step = 3'd2;
      `OP_SEC_EXIT: last_step = 3'd3;
      default: last_step = 3'd0;
    endcase
  end

  // address and data of each step; unlock pair leads program, erase and secured sequences
  always @* begin
    cyc_write = (op != `OP_READ);
    cyc_addr = `ADDR_UNLOCK1;
    cyc_data = `DATA_UNLOCK1;
    case (op)
      `OP_READ: begin
        // query offsets only: upper address forced low, see (RULE20)
        cyc_addr = query_mode ? {12'h000, target[7:0]} : target;
        cyc_data = 16'h0000;
      end
      `OP_QUERY: begin
        cyc_addr = `ADDR_QUERY;
        cyc_data = `DATA_QUERY;
      end
      `OP_RESET: begin
        cyc_addr = target; // any address will do, see (RULE19)
        cyc_data = `DATA_RESET;
      end
      default: begin
        // unlock cycles precede every program/erase, see (RULE7)
        case (step)
          3'd0: begin
            cyc_addr = `ADDR_UNLOCK1;
            cyc_data = `DATA_UNLOCK1;
          end
          3'd1, 3'd4: begin
            cyc_addr = `ADDR_UNLOCK2;
            cyc_data = `DATA_UNLOCK2;
          end
          3'd2: begin
            cyc_addr = `ADDR_UNLOCK1;
            case (op)
              `OP_PROGRAM: cyc_data = `DATA_PROGRAM;
              `OP_SEC_ENTER: cyc_data = `DATA_SEC_ENTER;
              `OP_SEC_EXIT: cyc_data = `DATA_SEC_EXIT1;
              default: cyc_data = `DATA_ERASE;
            endcase
          end
          3'd3: begin
            cyc_addr = (op == `OP_PROGRAM) ? target : `ADDR_UNLOCK1;
            case (op)
              `OP_PROGRAM: cyc_data = payload;
              `OP_SEC_EXIT: cyc_data = `DATA_SEC_EXIT2;
              default: cyc_data = `DATA_UNLOCK1;
            endcase
          end
          default: begin
            cyc_addr = (op == `OP_SECTOR_ERASE) ? target : `ADDR_UNLOCK1;
            cyc_data = (op == `OP_SECTOR_ERASE) ? `DATA_SECTOR_ERASE :
              `DATA_CHIP_ERASE;
          end
        endcase
      end
    endcase
  end

  flash_bus_cycle u_cycle (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .start(cyc_start),
    .is_write(cyc_write),
    .addr(cyc_addr),
    .wdata(cyc_data),
    .pin_dq_in(pin_dq_in),
    .busy(cyc_busy),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .pin_addr(b_addr),
    .pin_dq_out(b_dq),
    .pin_dq_oe(b_oe),
    .chip_sel_b(b_cs),
    .write_b(b_we),
    .gate_b(b_oe_b)
  );

  // register pins once more so every output is a flip-flop
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      pin_addr <= 20'h0_0000;
      pin_dq_out <= 16'h0000;
      pin_dq_oe <= 1'b0;
      chip_sel_b <= 1'b1; // see (RULE14)
      write_b <= 1'b1;
      gate_b <= 1'b1;
    end else begin
      pin_addr <= b_addr;
      pin_dq_out <= b_dq;
      pin_dq_oe <= b_oe;
      chip_sel_b <= b_cs;
      write_b <= b_we;
      gate_b <= b_oe_b;
    end
  end

  // operation sequencer; supply low stops new operations, one already started runs to its end
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      op <= `OP_READ;
      target <= 20'h0_0000;
      payload <= 16'h0000;
      step <= 3'd0;
      cyc_start <= 1'b0;
      op_ready <= 1'b0;
      op_done <= 1'b0;
      op_rdata <= 16'h0000;
      secured_mode <= 1'b0; // device reverts on reset, see (RULE12)
      query_mode <= 1'b0;
    end else begin
      cyc_start <= 1'b0;
      op_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          // writes under lockout are lost anyway, see (RULE13)
          op_ready <= ~low_s2 & ~op_ready;
          if (low_s2) begin
            secured_mode <= 1'b0;
            query_mode <= 1'b0;
          end else if (op_valid && op_ready) begin
            op_ready <= 1'b0;
            op <= op_code;
            target <= op_addr;
            payload <= op_data;
            step <= 3'd0;
            state <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          if (!cyc_busy) begin
            cyc_start <= 1'b1;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (cyc_done) begin
            if (step == last_step) begin
              // query data sits on the low byte, see (RULE21)
              op_rdata <= query_mode ? {8'h00, cyc_rdata[7:0]} :
                cyc_rdata;
              op_done <= 1'b1;
              if (op == `OP_SEC_ENTER) secured_mode <= 1'b1; // (RULE11)
              if (op == `OP_SEC_EXIT) secured_mode <= 1'b0;
              if (op == `OP_QUERY) query_mode <= 1'b1;
              if (op == `OP_RESET) query_mode <= 1'b0; // see (RULE20)
              state <= ST_IDLE;
            end else begin
              step <= step + 3'd1;
              state <= ST_ISSUE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

// ===== flash_host_assertions.sv
// pin-level checker for the flash host controller
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
`include "flash_host_regs.vh"
module flash_host_assertions (
  input logic clk_sys,
  input logic rst_b,
  input logic op_valid,
  input logic [2:0] op_code,
  input logic op_ready,
  input logic supply_low,
  input logic secured_mode,
  input logic query_mode,
  input logic [19:0] pin_addr,
  input logic [15:0] pin_dq_out,
  input logic pin_dq_oe,
  input logic chip_sel_b,
  input logic write_b,
  input logic gate_b
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic [15:0] last_wd;
  logic [19:0] last_wa;
  wire take = op_valid && op_ready;
  // previous write word, to judge unlock prefixes
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      last_wd <= 16'h0000;
      last_wa <= 20'h0_0000;
    end else if ($fell(write_b)) begin
      last_wd <= pin_dq_out;
      last_wa <= pin_addr;
    end
  end
  sequence s_cmd_byte;
    $fell(write_b) && pin_addr == `ADDR_UNLOCK1 &&
      pin_dq_out inside {16'h00A0, 16'h0080, 16'h0088, 16'h0090};
  endsequence
  sequence s_second_unlock;
    $fell(write_b) && pin_addr == `ADDR_UNLOCK2 && pin_dq_out == 16'h0055;
  endsequence
  // select held and gate high over the whole write pulse
  sequence s_wr_pulse;
    (!chip_sel_b && gate_b && pin_dq_oe)[*2] ##1 (write_b && !chip_sel_b);
  endsequence
  a_unlock_prefix: assert property (
    s_cmd_byte |-> last_wd == 16'h0055 && last_wa == `ADDR_UNLOCK2)
    else $error("command byte without unlock");
  a_unlock_order: assert property (
    s_second_unlock |-> last_wd == 16'h00AA && last_wa == `ADDR_UNLOCK1)
    else $error("second unlock out of order");
  a_write_qual: assert property (
    $fell(write_b) |-> s_wr_pulse)
    else $error("write strobe not qualified");
  a_never_all_low: assert property (
    !(!chip_sel_b && !write_b && !gate_b))
    else $error("all strobes low");
  a_idle_reset: assert property (
    $rose(rst_b) |-> chip_sel_b && write_b && gate_b && !pin_dq_oe)
    else $error("strobes active after reset");
  a_supply_hold: assert property (
    supply_low[*5] |-> !op_ready)
    else $error("ready during low supply");
  a_reset_cmd: assert property (
    take && op_code == `OP_RESET |->
      ##[1:30] ($fell(write_b) && pin_dq_out == 16'h00F0))
    else $error("reset word not written");
  a_exit_secured: assert property (
    take && op_code == `OP_SEC_EXIT |-> ##[1:80] !secured_mode)
    else $error("secured mode not left");
  // query reads must keep the address above the offset low
  a_query_addr: assert property (
    query_mode && !gate_b |-> pin_addr[19:8] == 12'h000)
    else $error("query read with upper address set");
endmodule
bind flash_host flash_host_assertions u_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .op_valid(op_valid),
  .op_code(op_code), .op_ready(op_ready), .supply_low(supply_low),
  .secured_mode(secured_mode), .query_mode(query_mode),
  .pin_addr(pin_addr),
  .pin_dq_out(pin_dq_out), .pin_dq_oe(pin_dq_oe),
  .chip_sel_b(chip_sel_b), .write_b(write_b), .gate_b(gate_b)
);

// ===== flash_model.sv
// behavioural word-mode nor flash on the host pins
// assumes bottom-boot mapping; reads settle after acc_ns
`timescale 1ns/1ps
module flash_model #(
  parameter int ACC_NS = 70,
  parameter bit OTP_LOCKED = 1'b1
) (
  input wire hw_reset_b,
  input wire supply_low,
  input wire [19:0] pin_addr,
  input wire [15:0] pin_dq_out,
  input wire chip_sel_b,
  input wire write_b,
  input wire gate_b,
  output logic [15:0] dev_dq = 16'h5A5A
);
  logic [15:0] mem [int];
  logic [15:0] otp [int];
  int step = 0;
  bit qry = 0;
  bit sec = 0;
  function automatic logic [15:0] cfi(input logic [7:0] a);
    case (a)
      8'h40: return 16'h0050;
      8'h41: return 16'h0052;
      8'h42: return 16'h0049;
      8'h43: return 16'h0031;
      8'h44: return 16'h0030;
      8'h46: return 16'h0002;
      8'h47, 8'h48: return 16'h0001;
      8'h49: return 16'h0004;
      default: return 16'h0000;
    endcase
  endfunction
  // lock word sits in bit 0 of the region base
  function automatic logic [15:0] rdm(input logic [19:0] a);
    // query table only answers when the upper address bits are zero
    if (qry) return (a[19:8] == 12'h000) ? cfi(a[7:0]) : 16'hFFFF;
    if (sec && a == 0) return {15'h0000, OTP_LOCKED};
    if (sec) return otp.exists(a) ? otp[a] : 16'hFFFF;
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction
  task automatic cmd(input logic [19:0] a, input logic [15:0] d);
    bit u1;
    bit u2;
    u1 = a == 20'h0_0555;
    u2 = a == 20'h0_02AA;
    if (d == 16'h00F0) begin
      step = 0;
      qry = 0;
      return;
    end
    // any wrong word falls back to array read
    case (step)
      0: begin
        if (a == 20'h0_0055 && d == 16'h0098) qry = 1;
        step = (u1 && d == 16'h00AA) ? 1 : 0;
      end
      1: step = (u2 && d == 16'h0055) ? 2 : 0;
      2: begin
        step = 0;
        if (u1 && d == 16'h00A0) step = 3;
        if (u1 && d == 16'h0080) step = 4;
        if (u1 && d == 16'h0088) sec = 1;
        if (u1 && d == 16'h0090) step = 7;
      end
      3: begin
        if (sec && a < 128 && !OTP_LOCKED) otp[a] = d;
        if (!sec) mem[a] = d;
        step = 0;
      end
      4: step = (u1 && d == 16'h00AA) ? 5 : 0;
      5: step = (u2 && d == 16'h0055) ? 6 : 0;
      6: begin
        if (!sec && d == 16'h0030)
          foreach (mem[k]) if (k >> 12 == a >> 12) mem[k] = 16'hFFFF;
        if (!sec && u1 && d == 16'h0010) mem.delete();
        step = 0;
      end
      7: begin
        if (d == 16'h0000) sec = 0;
        step = 0;
      end
    endcase
  endtask
  // hardware reset or low supply drop all command state
  always @(negedge hw_reset_b or posedge supply_low) begin
    step = 0;
    qry = 0;
    sec = 0;
  end
  // commands latch on the rising write strobe when qualified
  always @(posedge write_b) begin
    if (!chip_sel_b && gate_b && hw_reset_b && !supply_low)
      cmd(pin_addr, pin_dq_out);
  end
  // released bus flips, so a stale word never looks valid
  always @(pin_addr, chip_sel_b, gate_b) begin
    dev_dq <= #(ACC_NS) (!chip_sel_b && !gate_b) ?
      rdm(pin_addr) : ~dev_dq;
  end
endmodule

// ===== flash_host_bench.sv
// self-checking bench: flash host against the device model
// assumes the design header and flash_model
`timescale 1ns/1ps
`include "flash_host_regs.vh"
module flash_host_bench;
  logic clk_sys = 0;
  logic rst_b = 0;
  logic op_valid = 0;
  logic [2:0] op_code = 3'h0;
  logic [19:0] op_addr = 20'h0_0000;
  logic [15:0] op_data = 16'h0000;
  logic supply_low = 0;
  wire [15:0] pin_dq_in, pin_dq_out, dev_dq, op_rdata;
  wire [19:0] pin_addr;
  wire op_ready, op_done, secured_mode, query_mode;
  wire pin_dq_oe, chip_sel_b, write_b, gate_b;
  int n_mismatch = 0;
  int checked = 0;
  int a;
  logic [15:0] ref_mem [int];
  logic [15:0] rd;
  logic [15:0] qt [13] = '{16'h0050, 16'h0052, 16'h0049, 16'h0031,
    16'h0030, 16'h0000, 16'h0002, 16'h0001, 16'h0001, 16'h0004,
    16'h0000, 16'h0000, 16'h0000};
  always #12.5 clk_sys = ~clk_sys;
  assign pin_dq_in = pin_dq_oe ? pin_dq_out : dev_dq;
  flash_host u_dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .op_valid(op_valid), .op_code(op_code), .op_addr(op_addr),
    .op_data(op_data), .supply_low(supply_low), .pin_dq_in(pin_dq_in),
    .op_ready(op_ready), .op_done(op_done), .op_rdata(op_rdata),
    .secured_mode(secured_mode), .query_mode(query_mode),
    .pin_addr(pin_addr), .pin_dq_out(pin_dq_out), .pin_dq_oe(pin_dq_oe),
    .chip_sel_b(chip_sel_b), .write_b(write_b), .gate_b(gate_b));
  flash_model u_flash (.hw_reset_b(rst_b), .supply_low(supply_low),
    .pin_addr(pin_addr), .pin_dq_out(pin_dq_out), .chip_sel_b(chip_sel_b),
    .write_b(write_b), .gate_b(gate_b), .dev_dq(dev_dq));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // request held until taken; called and left 2 ns after an edge
  task automatic op(input logic [2:0] c, input logic [19:0] ad,
    input logic [15:0] d);
    int n;
    n = 0;
    op_code = c;
    op_addr = ad;
    op_data = d;
    op_valid = 1'b1;
    while (op_ready !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      #2;
      n++;
    end
    @(posedge clk_sys);
    #2;
    op_valid = 1'b0;
    while (op_done !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      #2;
      n++;
    end
    if (op_done !== 1'b1) begin
      n_mismatch++;
      finish_test;
    end else begin
      rd = op_rdata;
    end
  endtask
  task automatic verify;
    foreach (ref_mem[k]) begin
      op(`OP_READ, 20'(k), 16'h0000);
      chk(rd, ref_mem[k]);
    end
  endtask
  initial begin
    void'($urandom(91));
    repeat (16) @(posedge clk_sys);
    #2;
    rst_b = 1'b1;
    op(`OP_QUERY, 20'h0_0055, 16'h0000);
    chk({15'h0000, query_mode}, 16'h0001);
    // random upper address bits: the host has to clear them
    for (a = 0; a < 13; a++) begin
      op(`OP_READ, {12'($urandom), 8'(8'h40 + a)}, 16'h0000);
      chk(rd, qt[a]);
      chk({8'h00, rd[15:8]}, 16'h0000);
    end
    op(`OP_RESET, 20'h0_0040, 16'h0000);
    chk({15'h0000, query_mode}, 16'h0000);
    op(`OP_READ, 20'h0_0040, 16'h0000);
    chk(rd, 16'hFFFF);
    $display("query test done");
    ref_mem[0] = 16'h1234;
    repeat (6) ref_mem[32'h1000 + $urandom % 32'hE_0000] =
      16'($urandom) | 16'h0100;
    foreach (ref_mem[k]) op(`OP_PROGRAM, 20'(k), ref_mem[k]);
    verify;
    void'(ref_mem.last(a));
    op(`OP_SECTOR_ERASE, 20'(a), 16'h0000);
    foreach (ref_mem[k]) if (k >> 12 == a >> 12) ref_mem[k] = 16'hFFFF;
    verify;
    $display("program test done");
    op(`OP_SEC_ENTER, 20'h0_0000, 16'h0000);
    chk({15'h0000, secured_mode}, 16'h0001);
    op(`OP_READ, 20'h0_0000, 16'h0000);
    chk(rd, 16'h0001);
    op(`OP_PROGRAM, 20'h0_0005, 16'h1234);
    op(`OP_READ, 20'h0_0005, 16'h0000);
    chk(rd, 16'hFFFF);
    op(`OP_SEC_EXIT, 20'h0_0000, 16'h0000);
    chk({15'h0000, secured_mode}, 16'h0000);
    verify;
    op(`OP_SEC_ENTER, 20'h0_0000, 16'h0000);
    rst_b = 1'b0;
    repeat (3) @(posedge clk_sys);
    #2;
    rst_b = 1'b1;
    chk({15'h0000, secured_mode}, 16'h0000);
    verify;
    $display("secured test done");
    op(`OP_QUERY, 20'h0_0055, 16'h0000);
    supply_low = 1'b1;
    repeat (5) @(posedge clk_sys);
    repeat (8) begin
      @(posedge clk_sys);
      #2;
      chk({15'h0000, op_ready | query_mode}, 16'h0000);
    end
    supply_low = 1'b0;
    op(`OP_READ, 20'h0_0040, 16'h0000);
    chk(rd, 16'hFFFF);
    op(`OP_CHIP_ERASE, 20'h0_0000, 16'h0000);
    foreach (ref_mem[k]) ref_mem[k] = 16'hFFFF;
    verify;
    $display("supply and erase test done");
    finish_test;
  end
endmodule
